// file: dv/dslu_host.sv
// host serial controller model: frames words and records the echo
`timescale 1ns/1ps
module dslu_host (
  output logic o_sck,
  output logic o_sdi,
  output logic o_select_load_n,
  input wire logic i_sdo
);
  logic [31:0] echo;
  initial begin
    o_sck = 1'b0;
    o_sdi = 1'b0;
    o_select_load_n = 1'b1;
    echo = 32'h0000_0000;
  end
  // stray clocks with select high probe the frame gate; clock idles between frames
  task automatic frame(input logic [63:0] data, input int n, input int stray);
    repeat (stray) begin
      #16 o_sck = 1'b1;
      #16 o_sck = 1'b0;
    end
    #16 o_select_load_n = 1'b0;
    for (int k = n - 1; k >= 0; k--) begin
      o_sdi = data[k];
      #16 o_sck = 1'b1;
      echo = {echo[30:0], i_sdo};
      #16 o_sck = 1'b0;
    end
    #16 o_select_load_n = 1'b1;
    o_sdi = ~o_sdi;
    #128;
  endtask
endmodule

// file: dv/dslu_top_bench.sv
// self-checking bench for the serial load / update control block
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin fails++; \
  $display("unexpected %s: expected %h seen %h", nm, ex, got); end end
module dslu_top_bench;
  import dslu_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic upd_n = 1'b1;
  logic clr_n = 1'b1;
  logic refc = 1'b1;
  logic fsa = 1'b0;
  logic flt = 1'b0;
  logic sck, sdi, sel_n, sdo, sdo_oe, cmd_valid, cmd_short, update, ref_en, rfs, flt_oe, clr_act;
  logic flt_o;
  logic [WORD_BITS-1:0] cmd_word;
  int checks = 0;
  int fails = 0;
  int n_cmd = 0;
  int n_upd = 0;

  always #12.5 clk = ~clk;
  // pulses are counted so scenarios can wait on them
  always @(posedge clk) begin
    if (cmd_valid === 1'b1) n_cmd <= n_cmd + 1;
    if (update === 1'b1) n_upd <= n_upd + 1;
  end

  dslu_top i_dslu_top (.i_clk(clk), .i_resetn(resetn), .i_sck(sck), .i_sdi(sdi),
    .i_select_load_n(sel_n), .i_async_update_n(upd_n), .i_async_clear_n(clr_n),
    .i_reference_compensation_pin(refc), .i_full_scale_adjust_pin(fsa), .i_fault_event(flt),
    .o_sdo(sdo), .o_sdo_oe(sdo_oe), .o_cmd_valid(cmd_valid), .o_cmd_word(cmd_word),
    .o_cmd_short(cmd_short), .o_update(update), .o_ref_drive_en(ref_en), .o_int_rfs_sel(rfs),
    .o_fault_o(flt_o), .o_fault_oe(flt_oe), .o_clear_active(clr_act));
  dslu_host i_dslu_host (.o_sck(sck), .o_sdi(sdi), .o_select_load_n(sel_n), .i_sdo(sdo));

  task automatic wrap_up;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // bounded wait for a counted pulse
  task automatic wait_cnt(ref int cnt, input int was);
    for (int k = 0; k < 80; k++) begin
      if (cnt > was) return;
      @(posedge clk);
    end
    fails++;
    $display("unexpected pulse count: expected %0d seen %0d", was + 1, cnt);
    wrap_up();
  endtask

  task automatic do_reset(input logic strap);
    @(posedge clk);
    resetn <= 1'b0;
    refc <= strap;
    tick(12);
    resetn <= 1'b1;
    tick(10);
  endtask

  task automatic t_straps;
    `CHK("ref drive", 1'b1, ref_en)
    fsa <= 1'b1;
    tick(6);
    `CHK("int rfs", 1'b1, rfs)
    fsa <= 1'b0;
    tick(6);
    `CHK("int rfs", 1'b0, rfs)
    do_reset(1'b0);
    `CHK("ref drive", 1'b0, ref_en)
    do_reset(1'b1);
  endtask

  // stray clocks first: a counted one would make the frame illegal
  task automatic t_words;
    int was;
    was = n_cmd;
    i_dslu_host.frame(64'h0000_0000_a5c3_0f96, 32, 3);
    wait_cnt(n_cmd, was);
    `CHK("cmd word", 32'ha5c3_0f96, cmd_word)
    `CHK("cmd short", 1'b0, cmd_short)
    `CHK("sdo enable", 1'b0, sdo_oe)
    was = n_cmd;
    i_dslu_host.frame(64'h0000_0000_0012_3456, 24, 0);
    wait_cnt(n_cmd, was);
    `CHK("cmd word", 32'h0012_3456, cmd_word)
    `CHK("cmd short", 1'b1, cmd_short)
    was = n_cmd;
    i_dslu_host.frame(64'hdead_beef_1357_9bdf, 64, 0);
    wait_cnt(n_cmd, was);
    `CHK("cmd word", 32'h1357_9bdf, cmd_word)
    `CHK("echo word", 32'hdead_beef, i_dslu_host.echo)
  endtask

  task automatic t_fault;
    int was;
    was = n_cmd;
    i_dslu_host.frame(64'h0000_0000_0000_00a5, 8, 0);
    tick(8);
    `CHK("cmd count", was, n_cmd)
    `CHK("fault pull", 1'b1, flt_oe)
    `CHK("fault data", 1'b0, flt_o)
    was = n_cmd;
    i_dslu_host.frame(64'h0000_0000_0f0f_f0f0, 32, 0);
    wait_cnt(n_cmd, was);
    `CHK("fault pull", 1'b0, flt_oe)
    flt <= 1'b1;
    @(posedge clk);
    flt <= 1'b0;
    tick(2);
    `CHK("fault pull", 1'b1, flt_oe)
  endtask

  // second update edge falls mid-frame and must be lost
  task automatic t_update;
    int was;
    was = n_upd;
    upd_n <= 1'b0;
    wait_cnt(n_upd, was);
    tick(4);
    `CHK("update count", was + 1, n_upd)
    upd_n <= 1'b1;
    tick(4);
    was = n_upd;
    fork
      i_dslu_host.frame(64'h0000_0000_1111_2222, 32, 0);
      begin
        tick(10);
        upd_n <= 1'b0;
      end
    join
    tick(8);
    `CHK("update count", was, n_upd)
    upd_n <= 1'b1;
    tick(4);
  endtask

  task automatic t_clear;
    int was;
    clr_n <= 1'b0;
    tick(5);
    `CHK("clear state", 1'b1, clr_act)
    `CHK("fault pull", 1'b0, flt_oe)
    was = n_cmd;
    i_dslu_host.frame(64'h0000_0000_3333_4444, 32, 0);
    tick(8);
    `CHK("cmd count", was, n_cmd)
    `CHK("cmd word", 32'h0000_0000, cmd_word)
    clr_n <= 1'b1;
    tick(5);
    `CHK("clear state", 1'b0, clr_act)
  endtask

  initial begin
    tick(12);
    resetn <= 1'b1;
    tick(10);
    t_straps();
    t_words();
    t_fault();
    t_update();
    t_clear();
    wrap_up();
  end
endmodule

// file: dv/dslu_top_chk.sv
// checker on the ports of the serial load / update control block
`timescale 1ns/1ps
module dslu_top_chk #(
  parameter int WORD_W = dslu_pkg::WORD_BITS
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_select_load_n,
  input wire logic i_async_update_n,
  input wire logic i_async_clear_n,
  input wire logic i_reference_compensation_pin,
  input wire logic i_full_scale_adjust_pin,
  input wire logic i_fault_event,
  input wire logic o_sdo_oe,
  input wire logic o_cmd_valid,
  input wire logic o_update,
  input wire logic o_ref_drive_en,
  input wire logic o_int_rfs_sel,
  input wire logic o_fault_oe,
  input wire logic o_clear_active
);
  // all checks live in the core clock domain
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_resetn);

  // echo driver stays off while the frame is closed
  a_oe_closed: assert property (i_select_load_n |-> !o_sdo_oe)
    else $error("serial output enabled outside a frame");
  // a command only follows a select that has been high, and pulses once
  a_cmd_after_rise: assert property (o_cmd_valid |->
    $past(i_select_load_n, 1) && $past(i_select_load_n, 2) ##1 !o_cmd_valid)
    else $error("command pulse without a closed frame");
  a_upd_taken: assert property ($fell(i_async_update_n) && i_select_load_n &&
    $past(i_select_load_n, 3) && i_async_clear_n && $past(i_async_clear_n, 3) |-> ##[1:4] o_update)
    else $error("update edge with frame closed gave no pulse");
  a_upd_pulse: assert property (o_update |=> !o_update)
    else $error("update pulse longer than one cycle");
  // sync lag: select must be low a few cycles before the gate is certain
  a_upd_gated: assert property ((!i_select_load_n) [*6] |-> !o_update)
    else $error("update pulse during a frame");
  a_ref_strap: assert property ((!i_reference_compensation_pin) [*8] |-> !o_ref_drive_en)
    else $error("reference driven with grounded strap");
  a_rfs_follow: assert property (($stable(i_full_scale_adjust_pin)) [*5] |->
    o_int_rfs_sel == i_full_scale_adjust_pin)
    else $error("scaling resistor select does not follow pin");
  a_fault_set: assert property (i_fault_event && i_async_clear_n &&
    $past(i_async_clear_n, 1) && $past(i_async_clear_n, 2) |=> o_fault_oe)
    else $error("fault event not pulled low");
  a_fault_hold: assert property ((!i_select_load_n && i_async_clear_n) [*4] ##0 o_fault_oe
    |=> o_fault_oe)
    else $error("fault released inside a frame");
  a_fault_free: assert property (o_cmd_valid && !$past(i_fault_event) &&
    !$past(i_fault_event, 2) |-> !o_fault_oe)
    else $error("fault not released at select rise");
  a_clear_wins: assert property ((!i_async_clear_n) [*5] |->
    o_clear_active && !o_fault_oe && !o_cmd_valid)
    else $error("clear low did not zero state");

  c_cmd: cover property (o_cmd_valid);
  c_upd: cover property (o_update);
  c_fault_rel: cover property (o_fault_oe ##1 !o_fault_oe);
endmodule

bind dslu_top dslu_top_chk #(.WORD_W(WORD_W)) i_dslu_top_chk (.i_clk, .i_resetn,
  .i_select_load_n, .i_async_update_n, .i_async_clear_n, .i_reference_compensation_pin,
  .i_full_scale_adjust_pin, .i_fault_event, .o_sdo_oe, .o_cmd_valid, .o_update,
  .o_ref_drive_en, .o_int_rfs_sel, .o_fault_oe, .o_clear_active);

// file: src/dslu_link_if.sv
// link-domain shift state handed to the core clock domain
`timescale 1ns/1ps
interface dslu_link_if;
  import dslu_pkg::*;

  logic [WORD_BITS-1:0] word;
  logic [CNT_W-1:0] bit_cnt;
  logic wrapped;

  // shifter owns the word, core only looks at it after the frame
  modport shifter (output word, output bit_cnt, output wrapped);
  modport core (input word, input bit_cnt, input wrapped);
endinterface

// file: src/dslu_pkg.sv
// constants and types shared by the serial load / update control block
package dslu_pkg;

  // ----------------------------------------------------------------
  // serial word geometry
  // ----------------------------------------------------------------
  localparam int WORD_BITS = 32;
  localparam int SHORT_BITS = 24;
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] SHORT_CNT = 5'h18;
  localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;

  // ----------------------------------------------------------------
  // synchronised pin bundle, bit positions
  // ----------------------------------------------------------------
  localparam int PIN_W = 5;
  localparam int PIN_SEL = 0;
  localparam int PIN_UPD = 1;
  localparam int PIN_CLR = 2;
  localparam int PIN_REFC = 3;
  localparam int PIN_FSA = 4;
  localparam logic [PIN_W-1:0] PIN_RST = 5'h07;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [WORD_BITS-1:0] WORD_RST = 32'h0000_0000;
  localparam logic BIT_RST = 1'b0;
  localparam logic REF_EN_RST = 1'b1;

  // ----------------------------------------------------------------
  // timing: strap settle time after reset release
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 25000;
  localparam int STRAP_SETTLE_NS = 100;
  localparam int STRAP_SETTLE_CYC = (STRAP_SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int SETTLE_W = 3;

  // ----------------------------------------------------------------
  // core sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_SETTLE,
    ST_IDLE,
    ST_FRAME,
    ST_EXEC
  } dslu_state_e;

endpackage

// file: src/dslu_shifter.sv
// serial-clock domain: shift register, bit counter and echo output
`timescale 1ns/1ps
module dslu_shifter #(
  parameter int WORD_W = dslu_pkg::WORD_BITS
) (
  input wire logic i_sck,
  input wire logic i_resetn,
  input wire logic i_sdi,
  input wire logic i_select_load_n,
  output logic o_sdo,
  output logic o_sdo_oe,
  dslu_link_if.shifter lk
);
  import dslu_pkg::*;

  logic [WORD_W-1:0] sh_r;
  logic [WORD_W-1:0] sh_nxt;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic wrap_r;
  logic wrap_nxt;
  logic sdo_r;
  logic oe_r;
  logic first_r;
  logic first_nxt;
  logic frame_off;

  // select high ends the output driver asynchronously; the length count
  // must outlive the frame end, since the core reads it clocks later
  assign frame_off = i_select_load_n | ~i_resetn;

  // next shift state; edges with select high leave everything alone
  always_comb begin
    sh_nxt = sh_r;
    cnt_nxt = cnt_r;
    wrap_nxt = wrap_r;
    first_nxt = first_r;
    if (!i_select_load_n) begin
      sh_nxt = {sh_r[WORD_W-2:0], i_sdi};
      first_nxt = 1'b0;
      if (first_r) begin
        cnt_nxt = 5'h01;
        wrap_nxt = BIT_RST;
      end else begin
        cnt_nxt = cnt_r + 5'h01;
        wrap_nxt = wrap_r | (cnt_r == 5'h1f);
      end
    end
  end

  // word and length survive the frame end; core reads them once select is high
  always_ff @(posedge i_sck or negedge i_resetn) begin
    if (!i_resetn) begin
      sh_r <= WORD_RST;
      cnt_r <= CNT_ZERO;
      wrap_r <= BIT_RST;
    end else begin
      sh_r <= sh_nxt;
      cnt_r <= cnt_nxt;
      wrap_r <= wrap_nxt;
    end
  end

  // armed by every select high so the next frame counts from one;
  // limitation: a frame with no clock edge leaves the old length standing
  always_ff @(posedge i_sck or posedge frame_off) begin
    if (frame_off) begin
      first_r <= 1'b1;
    end else begin
      first_r <= first_nxt;
    end
  end

  // echo changes on falling edge, driver only inside the frame
  always_ff @(negedge i_sck or posedge frame_off) begin
    if (frame_off) begin
      sdo_r <= BIT_RST;
      oe_r <= BIT_RST;
    end else begin
      sdo_r <= sh_r[WORD_W-1];
      oe_r <= 1'b1;
    end
  end

  assign o_sdo = sdo_r;
  assign o_sdo_oe = oe_r;
  assign lk.word = sh_r[WORD_BITS-1:0];
  assign lk.bit_cnt = cnt_r;
  assign lk.wrapped = wrap_r;
endmodule

// file: src/dslu_sync.sv
// two flip-flop level synchroniser for a bundle of pins
`timescale 1ns/1ps
module dslu_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  import dslu_pkg::*;

  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] sync_r;
  logic [W-1:0] sync_nxt;

  // first stage feeds only the second stage
  always_comb begin
    meta_nxt = i_async;
    sync_nxt = meta_r;
  end

  // register both stages
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      meta_r <= RST_VAL;
      sync_r <= RST_VAL;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign o_sync = sync_r;
endmodule

// file: src/dslu_top.sv
// serial load framing, async update gating and power-up straps
`timescale 1ns/1ps

// Summary of operation
// - shift serial data only while select low
// - drive serial output only while select low
// - select rise: stop output, execute word
// - update falling edge copies inputs to converters
// - update input ignored while select low
// - internal reference drives pin by default
// - grounded compensation strap starts reference disabled
// - adjust pin high selects internal resistor
// - capture rising edge, 24/32/n*32 bit words
// - echo after 32 edges on falling edge
// - fault pulls low, released at select rise
// - clear low zeroes the fault at once, the word and short flag when a frame executes
module dslu_top #(
  parameter int WORD_W = dslu_pkg::WORD_BITS
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_sck,
  input wire logic i_sdi,
  input wire logic i_select_load_n,
  input wire logic i_async_update_n,
  input wire logic i_async_clear_n,
  input wire logic i_reference_compensation_pin,
  input wire logic i_full_scale_adjust_pin,
  input wire logic i_fault_event,
  output logic o_sdo,
  output logic o_sdo_oe,
  output logic o_cmd_valid,
  output logic [dslu_pkg::WORD_BITS-1:0] o_cmd_word,
  output logic o_cmd_short,
  output logic o_update,
  output logic o_ref_drive_en,
  output logic o_int_rfs_sel,
  output logic o_fault_o,
  output logic o_fault_oe,
  output logic o_clear_active
);
  import dslu_pkg::*;

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  // the counter is modulo 32 and the core word is 32 bits wide
  generate
    if (WORD_W != WORD_BITS) begin : g_bad_width
      $error("dslu_top: WORD_W must equal the 32-bit shift word");
    end
    if (STRAP_SETTLE_CYC < 1 || STRAP_SETTLE_CYC > 7) begin : g_bad_settle
      $error("dslu_top: strap settle count does not fit its counter");
    end
  endgenerate

  // ----------------------------------------------------------------
  // link domain
  // ----------------------------------------------------------------
  dslu_link_if lk ();

  // shift logic runs on the serial clock itself
  dslu_shifter #(
    .WORD_W(WORD_W)
  ) u_shifter (
    .i_sck(i_sck),
    .i_resetn(i_resetn),
    .i_sdi(i_sdi),
    .i_select_load_n(i_select_load_n),
    .o_sdo(o_sdo),
    .o_sdo_oe(o_sdo_oe),
    .lk(lk)
  );

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [PIN_W-1:0] pins_async;
  logic [PIN_W-1:0] pins_s;
  logic sel_s;
  logic upd_s;
  logic clr_s;
  logic refc_s;
  logic fsa_s;

  // every bundled pin is a level, two flops each before any core use; the shifter takes select directly and the fault event enters the core raw
  assign pins_async[PIN_SEL] = i_select_load_n;
  assign pins_async[PIN_UPD] = i_async_update_n;
  assign pins_async[PIN_CLR] = i_async_clear_n;
  assign pins_async[PIN_REFC] = i_reference_compensation_pin;
  assign pins_async[PIN_FSA] = i_full_scale_adjust_pin;

  dslu_sync #(
    .W(PIN_W),
    .RST_VAL(PIN_RST)
  ) u_pin_sync (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_async(pins_async),
    .o_sync(pins_s)
  );

  assign sel_s = pins_s[PIN_SEL];
  assign upd_s = pins_s[PIN_UPD];
  assign clr_s = pins_s[PIN_CLR];
  assign refc_s = pins_s[PIN_REFC];
  assign fsa_s = pins_s[PIN_FSA];

  // ----------------------------------------------------------------
  // edge history
  // ----------------------------------------------------------------
  logic sel_d_r;
  logic sel_d_nxt;
  logic upd_d_r;
  logic upd_d_nxt;
  logic sel_rise;
  logic upd_fall;

  // delayed copies of the synchronised levels
  always_comb begin
    sel_d_nxt = sel_s;
    upd_d_nxt = upd_s;
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      sel_d_r <= 1'b1;
      upd_d_r <= 1'b1;
    end else begin
      sel_d_r <= sel_d_nxt;
      upd_d_r <= upd_d_nxt;
    end
  end

  // edges are taken from the synchronised side only
  assign sel_rise = sel_s & ~sel_d_r;
  assign upd_fall = ~upd_s & upd_d_r;

  // ----------------------------------------------------------------
  // frame sequencer
  // ----------------------------------------------------------------
  dslu_state_e st_r;
  dslu_state_e st_nxt;
  logic [SETTLE_W-1:0] settle_r;
  logic [SETTLE_W-1:0] settle_nxt;
  logic cmd_valid_r;
  logic cmd_valid_nxt;
  logic [WORD_BITS-1:0] cmd_word_r;
  logic [WORD_BITS-1:0] cmd_word_nxt;
  logic cmd_short_r;
  logic cmd_short_nxt;
  logic ref_en_r;
  logic ref_en_nxt;
  logic len_err;
  logic len_short;
  logic len_long;

  // frame length check on the word left behind by the shifter;
  // the link values are quiet here because the serial clock has
  // stopped and select is high, so no word crossing is needed
  assign len_short = ~lk.wrapped & (lk.bit_cnt == SHORT_CNT);
  assign len_long = lk.wrapped & (lk.bit_cnt == CNT_ZERO);

  // sequencer next state
  always_comb begin
    st_nxt = st_r;
    settle_nxt = settle_r;
    cmd_valid_nxt = 1'b0;
    cmd_word_nxt = cmd_word_r;
    cmd_short_nxt = cmd_short_r;
    ref_en_nxt = ref_en_r;
    len_err = 1'b0;
    case (st_r)
      ST_SETTLE: begin
        // strap is caught after the release, once the pin has settled
        settle_nxt = settle_r + 3'h1;
        if (settle_r == SETTLE_W'(STRAP_SETTLE_CYC - 1)) begin
          ref_en_nxt = refc_s;
          st_nxt = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (!sel_s) begin
          st_nxt = ST_FRAME;
        end
      end
      ST_FRAME: begin
        // relies on the host closing the frame after its last edge
        if (sel_rise) begin
          st_nxt = ST_EXEC;
        end
      end
      ST_EXEC: begin
        st_nxt = ST_IDLE;
        if (len_short) begin
          cmd_valid_nxt = clr_s;
          cmd_word_nxt = {8'h00, lk.word[SHORT_BITS-1:0]};
          cmd_short_nxt = 1'b1;
        end else if (len_long) begin
          cmd_valid_nxt = clr_s;
          cmd_word_nxt = lk.word;
          cmd_short_nxt = 1'b0;
        end else begin
          // odd-length frame: nothing executes, fault is raised
          len_err = 1'b1;
        end
        if (!clr_s) begin
          cmd_word_nxt = WORD_RST;
          cmd_short_nxt = 1'b0;
        end
      end
      default: begin
        st_nxt = ST_IDLE;
      end
    endcase
  end

  // sequencer registers
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st_r <= ST_SETTLE;
      settle_r <= '0;
      cmd_valid_r <= 1'b0;
      cmd_word_r <= WORD_RST;
      cmd_short_r <= 1'b0;
      ref_en_r <= REF_EN_RST;
    end else begin
      st_r <= st_nxt;
      settle_r <= settle_nxt;
      cmd_valid_r <= cmd_valid_nxt;
      cmd_word_r <= cmd_word_nxt;
      cmd_short_r <= cmd_short_nxt;
      ref_en_r <= ref_en_nxt;
    end
  end

  // ----------------------------------------------------------------
  // update, clear, scaling and fault
  // ----------------------------------------------------------------
  logic update_r;
  logic update_nxt;
  logic clear_r;
  logic clear_nxt;
  logic rfs_r;
  logic rfs_nxt;
  logic fault_r;
  logic fault_nxt;

  // side pins: update gated by select, fault held until select rise
  always_comb begin
    // gating on the synchronised select level can miss an update edge
    // that lands within two clocks of a select change
    update_nxt = upd_fall & sel_s & clr_s;
    clear_nxt = ~clr_s;
    rfs_nxt = fsa_s;
    fault_nxt = fault_r;
    if (sel_rise) begin
      fault_nxt = 1'b0;
    end
    // a new fault in the release cycle is kept
    if (i_fault_event | len_err) begin
      fault_nxt = 1'b1;
    end
    // clear is a reset of the control state and wins over all
    if (!clr_s) begin
      fault_nxt = 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      update_r <= 1'b0;
      clear_r <= 1'b0;
      rfs_r <= 1'b0;
      fault_r <= 1'b0;
    end else begin
      update_r <= update_nxt;
      clear_r <= clear_nxt;
      rfs_r <= rfs_nxt;
      fault_r <= fault_nxt;
    end
  end

  // open-drain fault: data is always low, enable pulls the wire
  logic fault_o_r;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      fault_o_r <= 1'b0;
    end else begin
      fault_o_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign o_cmd_valid = cmd_valid_r;
  assign o_cmd_word = cmd_word_r;
  assign o_cmd_short = cmd_short_r;
  assign o_update = update_r;
  assign o_ref_drive_en = ref_en_r;
  assign o_int_rfs_sel = rfs_r;
  assign o_fault_o = fault_o_r;
  assign o_fault_oe = fault_r;
  assign o_clear_active = clear_r;
endmodule
